//--- synth_serial_divider_load.sv
/*
 * Serial programming port and divider latches of the frequency synthesizer.
 * Holds the 20-bit data shift register, the feedback, reference and
 * function latches, the feedback divide ratio and the receive power-down
 * selection.
 * Assumes the serial clock, data, load strobe and power-down pin are
 * asynchronous to clk and each stays at a level for well over three clk
 * periods; the serial clock runs much slower than clk.
 */
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Data sampled on serial clock rising edge
// - Twenty-bit words, most significant bit first
// - Last two bits select the destination latch
// - Load strobe rise copies payload to target
// - 00 feedback, 10 reference, x1 function latch
// - Bits 7..2 swallow, 13..8 main count
// - Reference write loads bits 7..2
// - Feedback ratio is modulus times main plus swallow
// - Shift, function, feedback, reference latch widths
// - Receive power-down from pin or software bit
// - Function latch takes word bits 19..2
// - 00 software, 11 pin, mixed reserved
module synth_serial_divider_load
	import synth_prog_pkg::*;
(
	input wire logic clk, // Core clock, 200 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic ser_clk, // Serial clock pin
	input wire logic ser_data, // Serial data pin
	input wire logic load_strobe, // Load strobe pin
	input wire logic receive_powerdown_pin, // Hardware power-down pin
	output divider_cfg_s div_cfg, // Swallow, main and reference counts
	output logic [FUNC_W-1:0] func_latch, // Function latch contents
	output logic [RATIO_W-1:0] feedback_ratio, // Total feedback division
	output logic rx_chain_off, // Receive chain powered down
	output logic pd_test_mode, // Reserved power-down setting in use
	output logic load_done // One-cycle pulse after each load
);

	// Decode the select field of a word into a destination
	function automatic dest_e dest_decode(input logic [SEL_W-1:0] sel);
		dest_e d;
		d = DEST_FUNCTION;
		if (sel == SEL_FEEDBACK) begin
			d = DEST_FEEDBACK;
		end else if (sel == SEL_REFERENCE) begin
			d = DEST_REFERENCE;
		end
		return d;
	endfunction

	// Total division of the dual-modulus feedback path
	function automatic logic [RATIO_W-1:0] fb_total(
		input logic high_mod,
		input logic [CNT_W-1:0] main_cnt,
		input logic [CNT_W-1:0] swallow_cnt
	);
		logic [RATIO_W-1:0] prod;
		prod = {{(RATIO_W-CNT_W){1'b0}}, main_cnt};
		if (high_mod) begin
			prod = prod << MOD_HIGH_SHIFT;
		end else begin
			prod = prod << MOD_LOW_SHIFT;
		end
		return prod + {{(RATIO_W-CNT_W){1'b0}}, swallow_cnt};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [SYNC_W-1:0] sclk_sync_ff;
	logic [SYNC_W-1:0] sdat_sync_ff;
	logic [SYNC_W-1:0] strb_sync_ff;
	logic [SYNC_W-1:0] pdpin_sync_ff;
	logic sclk_lvl_ff;
	logic sdat_lvl_ff;
	logic strb_lvl_ff;
	logic pdpin_lvl_ff;

	// Three stages per pin; only stage two feeds stage three
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_sync_ff <= '0;
			sdat_sync_ff <= '0;
			strb_sync_ff <= '0;
			pdpin_sync_ff <= '0;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], ser_clk};
			sdat_sync_ff <= {sdat_sync_ff[1:0], ser_data};
			strb_sync_ff <= {strb_sync_ff[1:0], load_strobe};
			pdpin_sync_ff <= {pdpin_sync_ff[1:0], receive_powerdown_pin};
		end
	end

	// A level counts once stages two and three agree, filtering glitches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_lvl_ff <= 1'b0;
			sdat_lvl_ff <= 1'b0;
			strb_lvl_ff <= 1'b0;
			pdpin_lvl_ff <= 1'b0;
		end else begin
			if (sclk_sync_ff[1] == sclk_sync_ff[2]) begin
				sclk_lvl_ff <= sclk_sync_ff[2];
			end
			if (sdat_sync_ff[1] == sdat_sync_ff[2]) begin
				sdat_lvl_ff <= sdat_sync_ff[2];
			end
			if (strb_sync_ff[1] == strb_sync_ff[2]) begin
				strb_lvl_ff <= strb_sync_ff[2];
			end
			if (pdpin_sync_ff[1] == pdpin_sync_ff[2]) begin
				pdpin_lvl_ff <= pdpin_sync_ff[2];
			end
		end
	end

	// Edges of the filtered levels
	logic sclk_rise;
	logic strb_rise;
	assign sclk_rise = (sclk_sync_ff[1] == sclk_sync_ff[2])
		&& sclk_sync_ff[2] && !sclk_lvl_ff;
	assign strb_rise = (strb_sync_ff[1] == strb_sync_ff[2])
		&& strb_sync_ff[2] && !strb_lvl_ff;

	////////////////////////////////////////////////////////////////////////
	// Data shift register

	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] nxt_shift;

	// Data path lags clock by one stage more, so data must settle one clk earlier
	assign nxt_shift = {shift_ff[WORD_W-2:0], sdat_lvl_ff};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_ff <= SHIFT_RST;
		end else if (sclk_rise) begin
			shift_ff <= nxt_shift;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Latch loading

	dest_e load_dest;
	assign load_dest = dest_decode(shift_ff[SEL_LSB +: SEL_W]);

	logic [CNT_W-1:0] swallow_ff;
	logic [CNT_W-1:0] main_ff;
	logic [CNT_W-1:0] ref_ff;
	logic [FUNC_W-1:0] func_ff;
	logic load_done_ff;

	// Feedback latch: both counts move together in one load
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			swallow_ff <= CNT_RST;
			main_ff <= CNT_RST;
		end else if (strb_rise && load_dest == DEST_FEEDBACK) begin
			swallow_ff <= shift_ff[SWALLOW_LSB +: CNT_W];
			main_ff <= shift_ff[MAIN_LSB +: CNT_W];
		end
	end

	// Reference latch; upper word bits are don't-care
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_ff <= CNT_RST;
		end else if (strb_rise && load_dest == DEST_REFERENCE) begin
			ref_ff <= shift_ff[REF_LSB +: CNT_W];
		end
	end

	// Function latch; other latches hold while it loads
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			func_ff <= FUNC_RST;
		end else if (strb_rise && load_dest == DEST_FUNCTION) begin
			func_ff <= shift_ff[FUNC_LSB +: FUNC_W];
		end
	end

	// Completion pulse; the shift register is left as is for reuse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_done_ff <= 1'b0;
		end else begin
			load_done_ff <= strb_rise;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divide ratio and power-down

	logic [RATIO_W-1:0] ratio_ff;
	logic rx_off_ff;
	logic pd_test_ff;

	// Registered ratio; no range check, the controller keeps values legal
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ratio_ff <= '0;
		end else begin
			ratio_ff <= fb_total(func_ff[FB_PRESCALER], main_ff,
				swallow_ff);
		end
	end

	// Method chosen by the two select bits; test settings keep rx powered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_off_ff <= 1'b0;
			pd_test_ff <= 1'b0;
		end else begin
			case ({func_ff[FB_PD_SEL_B], func_ff[FB_PD_SEL_A]})
				2'h0: begin
					rx_off_ff <= func_ff[FB_RX_OFF];
					pd_test_ff <= 1'b0;
				end
				2'h3: begin
					rx_off_ff <= pdpin_lvl_ff;
					pd_test_ff <= 1'b0;
				end
				default: begin
					rx_off_ff <= 1'b0;
					pd_test_ff <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign div_cfg = '{swallow_count: swallow_ff, main_count: main_ff,
		ref_count: ref_ff};
	assign func_latch = func_ff;
	assign feedback_ratio = ratio_ff;
	assign rx_chain_off = rx_off_ff;
	assign pd_test_mode = pd_test_ff;
	assign load_done = load_done_ff;

endmodule

`default_nettype wire

//--- synth_prog_pkg.sv
/*
 * Constants and carrier types for the synthesizer serial programming port:
 * word layout, destination select codes, function latch bit positions,
 * prescaler moduli and reset values of the divider latches.
 * Assumes a single 200 MHz core clock and the port pins sampled by it.
 */
`default_nettype none

package synth_prog_pkg;

	// Word and latch sizes
	localparam int WORD_W = 20;
	localparam int FUNC_W = 18;
	localparam int CNT_W = 6;
	localparam int RATIO_W = 13;
	localparam int SYNC_W = 3;

	// Destination select field, word bits 1..0
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 2;
	localparam logic [1:0] SEL_FEEDBACK = 2'h0;
	localparam logic [1:0] SEL_REFERENCE = 2'h2;

	// Payload field positions within the word
	localparam int SWALLOW_LSB = 2;
	localparam int MAIN_LSB = 8;
	localparam int REF_LSB = 2;
	localparam int FUNC_LSB = 2;

	// Function latch bit positions (latch bit 0 holds word bit 2)
	localparam int FB_PRESCALER = 0;
	localparam int FB_RX_OFF = 5;
	localparam int FB_PD_SEL_A = 10;
	localparam int FB_PD_SEL_B = 11;

	// Prescaler moduli; both moduli are power of two shifts
	localparam int MOD_LOW_SHIFT = 5;
	localparam int MOD_HIGH_SHIFT = 6;

	// Reset values of the latches
	localparam logic [WORD_W-1:0] SHIFT_RST = 20'h00000;
	localparam logic [FUNC_W-1:0] FUNC_RST = 18'h00000;
	localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

	// Destination of a load
	typedef enum logic [2:0] {
		DEST_FEEDBACK = 3'h1,
		DEST_REFERENCE = 3'h2,
		DEST_FUNCTION = 3'h4
	} dest_e;

	// Divider settings that travel together
	typedef struct packed {
		logic [CNT_W-1:0] swallow_count;
		logic [CNT_W-1:0] main_count;
		logic [CNT_W-1:0] ref_count;
	} divider_cfg_s;

endpackage

`default_nettype wire

//--- synth_chk.sv
/* Assertions on the synth serial port outputs.
 Bound by name to the top module; one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module synth_chk
	import synth_prog_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic load_strobe, // Load pin
	input wire logic receive_powerdown_pin, // Pd pin
	input wire divider_cfg_s div_cfg, // Counts
	input wire logic [FUNC_W-1:0] func_latch, // Function latch
	input wire logic [RATIO_W-1:0] feedback_ratio, // Ratio
	input wire logic rx_chain_off, // Rx off
	input wire logic pd_test_mode, // Reserved mode flag
	input wire logic load_done // Load pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
////////////////////////////////////////////////////////////////
	// Ratio trails the latches by one cycle
	property p_ratio;
		feedback_ratio == (13'($past(div_cfg.main_count))
			<< ($past(func_latch[0]) ? 6 : 5))
			+ 13'($past(div_cfg.swallow_count));
	endproperty
	a_ratio: assert property (p_ratio)
		else $error("ratio mismatch");
	property p_done_once;
		load_done |=> !load_done;
	endproperty
	a_done_once: assert property (p_done_once)
		else $error("done too long");
	// Pipeline is three to four cycles, so the pin was high two back
	property p_done_cause;
		load_done |-> $past(load_strobe, 2);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done without strobe");
	property p_load_cause;
		$changed(div_cfg) || $changed(func_latch) |-> $past(load_strobe, 2);
	endproperty
	a_load_cause: assert property (p_load_cause)
		else $error("latch moved alone");
	property p_ref_alone;
		$changed(div_cfg.ref_count)
			|-> $stable(func_latch) && $stable(div_cfg[17:6]);
	endproperty
	a_ref_alone: assert property (p_ref_alone)
		else $error("ref load disturbed others");
	property p_fb_alone;
		$changed(div_cfg[17:6])
			|-> $stable(func_latch) && $stable(div_cfg.ref_count);
	endproperty
	a_fb_alone: assert property (p_fb_alone)
		else $error("feedback load disturbed others");
	property p_sw_pd;
		$past(func_latch[11:10]) == 2'h0 |-> rx_chain_off == $past(func_latch[5]);
	endproperty
	a_sw_pd: assert property (p_sw_pd)
		else $error("software power-down wrong");
	property p_test_md;
		pd_test_mode == $past(^func_latch[11:10]);
	endproperty
	a_test_md: assert property (p_test_md)
		else $error("test flag wrong");
	// Pin filter adds latency, so wait for it to stand still first
	property p_hw_pd;
		(func_latch[11:10] == 2'h3 && $stable(receive_powerdown_pin)) [*8]
			|-> rx_chain_off == receive_powerdown_pin;
	endproperty
	a_hw_pd: assert property (p_hw_pd)
		else $error("pin power-down wrong");
endmodule
bind synth_serial_divider_load synth_chk chk_u (.clk(clk), .rst_n(rst_n),
	.load_strobe(load_strobe), .receive_powerdown_pin(receive_powerdown_pin),
	.div_cfg(div_cfg), .func_latch(func_latch), .feedback_ratio(feedback_ratio),
	.rx_chain_off(rx_chain_off), .pd_test_mode(pd_test_mode),
	.load_done(load_done));
`default_nettype wire

//--- ser_ctrl_model.sv
/* Serial controller model driving the programming pins.
 The bench calls send; timing is its own, unrelated to clk. */
`timescale 1ns/100ps
`default_nettype none
module ser_ctrl_model (
	output logic ser_clk, // Serial clock, still between words
	output logic ser_data, // Serial data
	output logic load_strobe // Load strobe
);
	// Idle low until the first word
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		load_strobe = 1'b0;
	end
	// One word at 48 ns per bit, then a load pulse
	// Non-blocking so a change that meets a clk edge is seen after it
	task automatic send(input logic [19:0] w);
		for (int i = 19; i >= 0; i--) begin
			ser_data <= w[i];
			#24 ser_clk <= 1'b1;
			#24 ser_clk <= 1'b0;
		end
		ser_data <= ~w[0]; // Hold over, line no longer valid
		#30 load_strobe <= 1'b1;
		#50 load_strobe <= 1'b0;
		#30;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
/* Self-checking bench for the synth serial port.
 Serial pins come from ser_ctrl_model; checker is bound. */
`timescale 1ns/100ps
`default_nettype none
module tb
	import synth_prog_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pd_pin = 1'b0;
	wire ser_clk, ser_data, load_strobe;
	divider_cfg_s cfg;
	logic [FUNC_W-1:0] func;
	logic [RATIO_W-1:0] ratio;
	logic rx_off, test_md, done;
	int err_count = 0;
	int n_tests = 0;
	int n_done = 0;
	// 200 MHz core clock
	always #2.5 clk = ~clk;
	// Count load pulses; a stuck pulse counts more than once
	always @(posedge clk) begin
		if (done === 1'b1) begin
			n_done <= n_done + 1;
		end
	end
	synth_serial_divider_load dut_u (.clk(clk), .rst_n(rst_n),
		.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
		.receive_powerdown_pin(pd_pin), .div_cfg(cfg), .func_latch(func),
		.feedback_ratio(ratio), .rx_chain_off(rx_off),
		.pd_test_mode(test_md), .load_done(done));
	ser_ctrl_model ctl_u (.ser_clk(ser_clk), .ser_data(ser_data),
		.load_strobe(load_strobe));
////////////////////////////////////////////////////////////////
	// Compare one value
	task automatic chk(input string nm, input logic [17:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Swallow 21, main 42, junk in the ignored top bits
	task automatic t_feedback();
		ctl_u.send({6'h3f, 6'h2a, 6'h15, 2'h0});
		chk("swallow", 18'h15, cfg.swallow_count);
		chk("main", 18'h2a, cfg.main_count);
		chk("ref", 18'h0, cfg.ref_count);
		chk("ratio32", 18'h555, ratio);
		chk("loads", 18'h1, n_done[17:0]);
	endtask
	task automatic t_reference();
		ctl_u.send({12'hfff, 6'h3f, 2'h2});
		chk("ref", 18'h3f, cfg.ref_count);
		chk("main", 18'h2a, cfg.main_count);
		chk("func", 18'h0, func);
	endtask
	// Select 11 still means function latch; prescaler 64, pin mode
	task automatic t_function();
		ctl_u.send({18'h2ac01, 2'h3});
		chk("func", 18'h2ac01, func);
		chk("ratio64", 18'ha95, ratio);
		chk("cfg", 18'h15abf, cfg);
		@(posedge clk) pd_pin <= 1'b1;
		repeat (10) @(posedge clk);
		chk("rx_pin1", 18'h1, rx_off);
		@(posedge clk) pd_pin <= 1'b0;
		repeat (10) @(posedge clk);
		chk("rx_pin0", 18'h1, {17'h0, ~rx_off});
	endtask
	// Pin held high must be ignored outside pin mode
	task automatic t_software();
		@(posedge clk) pd_pin <= 1'b1;
		ctl_u.send({18'h00000, 2'h1});
		chk("rx_sw0", 18'h0, rx_off);
		chk("ratio32", 18'h555, ratio);
		ctl_u.send({18'h00020, 2'h1});
		chk("rx_sw1", 18'h1, rx_off);
		ctl_u.send({18'h00420, 2'h1});
		chk("rx_test", 18'h0, rx_off);
		chk("test_md", 18'h1, test_md);
		ctl_u.send({18'h00820, 2'h1});
		chk("rx_test2", 18'h0, rx_off);
		chk("test_md2", 18'h1, test_md);
		chk("loads", 18'h7, n_done[17:0]);
	endtask
	// Reset, then the scenarios in order
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("ratio_rst", 18'h0, ratio);
		t_feedback();
		t_reference();
		t_function();
		t_software();
		end_of_test();
	end
	// Run takes about 8 us; cut a hang well beyond that
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
